// ### rtl/capture_compare_unit.sv
// Capture and compare unit: edge capture of the time base and match actions
`timescale 1ns/1ps
`include "ccu_consts.svh"

// What this block does
// RL1 - Capture copies time base into value pair
// RL2 - Mode picks falling, rising, fourth, sixteenth edge
// RL3 - Capture sets flag; only software clears it
// RL4 - Newer capture overwrites older value unprotected
// RL5 - Three-bit select chooses one of eight sources
// RL6 - Own output transitions still cause captures
// RL7 - Time base must run synchronous modes
// RL8 - Mode change may spuriously set flag
// RL9 - Time base clocked by instruction or external
// RL10 - Prescaler cleared when off, noncapture, reset
// RL11 - Ratio change keeps prescaler; write zero first
// RL12 - Capture keeps working when time base runs
// RL13 - Compare match performs mode-selected action
// RL14 - Every match sets flag with pin action
// RL15 - Zero control clears compare output latch
// RL16 - Compare output offered to other peripherals
// RL17 - Match with trigger selected issues conversion trigger
// RL18 - Trigger mode resets time base if match persists
// RL19 - Enabled match interrupt wakes the device
// RL20 - Each instance independent with own registers
// RL21 - Software routes output pin and direction
// RL22 - Mode codes chosen here, zero is disabled
module capture_compare_unit
    import ccu_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_ctrl_we,
    input  wire logic [7:0]  i_ctrl_wdata,
    input  wire logic        i_src_we,
    input  wire logic [2:0]  i_src_wdata,
    input  wire logic        i_value_low_we,
    input  wire logic        i_value_high_we,
    input  wire logic [7:0]  i_value_wdata,
    input  wire logic        i_flag_clear,
    input  wire logic        i_unit_event_enable,
    input  wire logic        i_trigger_selected,
    output logic [7:0]       o_unit_control_reg,
    output logic [7:0]       o_value_low_byte,
    output logic [7:0]       o_value_high_byte,
    output logic [2:0]       o_capture_source_reg,
    ccu_if.unit              bus
);
    logic [7:0]  ctrl_reg;
    logic [2:0]  src_reg;
    logic [15:0] value_reg;
    logic [3:0]  presc_reg;
    logic        flag_reg;
    logic        out_reg;
    logic        trig_reg;
    logic        trig_pend_reg;
    logic        tb_rst_reg;
    logic        wake_reg;
    logic        src_meta_reg;
    logic        src_sync_reg;
    logic        src_prev_reg;
    logic        src_raw;
    logic        rise;
    logic        fall;
    logic        cap_event;
    logic        match;
    logic        match_event;
    logic        match_prev_reg;
    logic [15:0] match_value_reg;
    mode_t       mode;
    mode_class_t mclass;

    // Classify a mode code into off, capture or compare
    function automatic mode_class_t classify(input logic en, input mode_t m);
        if (!en || m == `CCU_MODE_OFF)
            return CLASS_OFF;
        else if (m >= `CCU_MODE_CAP_FALL && m <= `CCU_MODE_CAP_RISE16)
            return CLASS_CAPTURE;
        else if (m == `CCU_MODE_CMP_TOGGLE || (m >= `CCU_MODE_CMP_SET && m <= `CCU_MODE_CMP_TRIG))
            return CLASS_COMPARE;
        else
            return CLASS_OFF;
    endfunction

    assign mode   = ctrl_reg[`CCU_CTRL_MODE_LSB +: 4]; // RL22
    assign mclass = classify(ctrl_reg[`CCU_CTRL_EN_BIT], mode);

    // Source selection among eight inputs
    always_comb begin
        case (src_reg) // RL5
            3'h0:    src_raw = bus.remapped_input_pin;
            3'h1:    src_raw = bus.comparator_one_synced;
            3'h2:    src_raw = bus.comparator_two_synced;
            3'h3:    src_raw = bus.pin_change_event;
            3'h4:    src_raw = bus.logic_cell_outputs[0];
            3'h5:    src_raw = bus.logic_cell_outputs[1];
            3'h6:    src_raw = bus.logic_cell_outputs[2];
            3'h7:    src_raw = bus.logic_cell_outputs[3];
            default: src_raw = 1'b0;
        endcase
    end

    // Two-stage synchroniser then edge history; the pin level, even self-driven, is sampled
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            src_meta_reg <= 1'b0;
            src_sync_reg <= 1'b0;
            src_prev_reg <= 1'b0;
        end else begin
            src_meta_reg <= src_raw; // RL6
            src_sync_reg <= src_meta_reg;
            src_prev_reg <= src_sync_reg;
        end
    end

    assign rise = src_sync_reg & ~src_prev_reg;
    assign fall = ~src_sync_reg & src_prev_reg;

    // Capture event decode including prescaler terminal counts
    always_comb begin
        cap_event = 1'b0;
        if (mclass == CLASS_CAPTURE) begin
            case (mode) // RL2
                `CCU_MODE_CAP_FALL:   cap_event = fall;
                `CCU_MODE_CAP_RISE:   cap_event = rise;
                `CCU_MODE_CAP_RISE4:  cap_event = rise && presc_reg[1:0] == `CCU_PRESC_LAST4;
                `CCU_MODE_CAP_RISE16: cap_event = rise && presc_reg == `CCU_PRESC_LAST16;
                default:              cap_event = 1'b0;
            endcase
        end
    end

    // Prescaler counts rising edges; not cleared on ratio change
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            presc_reg <= `CCU_PRESC_RESET; // RL10
        else if (mclass != CLASS_CAPTURE)
            presc_reg <= `CCU_PRESC_RESET; // RL10
        else if (rise)
            presc_reg <= presc_reg + 4'h1; // RL11
    end

    // Compare detects the onset of equality so a held timer matches once
    assign match       = (mclass == CLASS_COMPARE) && (bus.time_base_count == value_reg); // RL13
    assign match_event = match && !match_prev_reg;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            match_prev_reg <= 1'b0;
        else
            match_prev_reg <= match;
    end

    // Control and source registers
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_reg <= `CCU_CTRL_RESET;
            src_reg  <= `CCU_SRC_RESET;
        end else begin
            if (i_ctrl_we)
                ctrl_reg <= i_ctrl_wdata; // RL20
            if (i_src_we)
                src_reg <= i_src_wdata;
        end
    end

    // Value pair: software writes bytes; capture overwrites the whole word
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            value_reg <= `CCU_VALUE_RESET;
        else if (cap_event)
            value_reg <= bus.time_base_count; // RL1 RL4 RL12
        else begin
            if (i_value_low_we)
                value_reg[7:0] <= i_value_wdata;
            if (i_value_high_we)
                value_reg[15:8] <= i_value_wdata;
        end
    end

    // Event flag: hardware set wins over software clear
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            flag_reg <= 1'b0;
        else if (cap_event || match_event)
            flag_reg <= 1'b1; // RL3 RL8 RL14
        else if (i_flag_clear)
            flag_reg <= 1'b0; // RL3
    end

    // Compare output latch
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            out_reg <= 1'b0;
        else if (i_ctrl_we && i_ctrl_wdata == `CCU_CTRL_RESET)
            out_reg <= 1'b0; // RL15
        else if (match_event) begin
            case (mode) // RL13
                `CCU_MODE_CMP_TOGGLE: out_reg <= ~out_reg;
                `CCU_MODE_CMP_SET:    out_reg <= 1'b1;
                `CCU_MODE_CMP_CLEAR:  out_reg <= 1'b0;
                default:              out_reg <= out_reg;
            endcase
        end
    end

    // Conversion trigger pulse, then time-base reset one edge later unless the pair moved;
    // the running count has already stepped past the target, so only the pair is watched
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            trig_reg        <= 1'b0;
            trig_pend_reg   <= 1'b0;
            tb_rst_reg      <= 1'b0;
            match_value_reg <= `CCU_VALUE_RESET;
        end else begin
            trig_reg        <= match_event && i_trigger_selected; // RL17
            trig_pend_reg   <= match_event && mode == `CCU_MODE_CMP_TRIG;
            match_value_reg <= value_reg;
            tb_rst_reg      <= trig_pend_reg && value_reg == match_value_reg; // RL18
        end
    end

    // Wake request while an enabled flag stands
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            wake_reg <= 1'b0;
        else
            wake_reg <= flag_reg && i_unit_event_enable; // RL19
    end

    assign bus.compare_output     = out_reg; // RL16
    assign bus.conversion_trigger = trig_reg;
    assign bus.time_base_reset    = tb_rst_reg;
    assign bus.unit_event_flag    = flag_reg;
    assign bus.wake_request       = wake_reg;
    assign o_unit_control_reg     = {ctrl_reg[7], 1'b0, out_reg, ctrl_reg[4:0]};
    assign o_value_low_byte       = value_reg[7:0];
    assign o_value_high_byte      = value_reg[15:8];
    assign o_capture_source_reg   = src_reg;
endmodule // capture_compare_unit

// ### inc/ccu_consts.svh
// Constants for the capture and compare unit: field positions, mode codes, reset values
`ifndef CCU_CONSTS_SVH
`define CCU_CONSTS_SVH
`define CCU_CTRL_EN_BIT     7
`define CCU_CTRL_OUT_BIT    5
`define CCU_CTRL_MODE_LSB   0
`define CCU_CTRL_RESET      8'h00
`define CCU_VALUE_RESET     16'h0000
`define CCU_SRC_RESET       3'h0
`define CCU_PRESC_RESET     4'h0
`define CCU_PRESC_LAST4     4'h3
`define CCU_PRESC_LAST16    4'hF
`define CCU_MODE_OFF        4'h0
`define CCU_MODE_CMP_TOGGLE 4'h2
`define CCU_MODE_CAP_FALL   4'h4
`define CCU_MODE_CAP_RISE   4'h5
`define CCU_MODE_CAP_RISE4  4'h6
`define CCU_MODE_CAP_RISE16 4'h7
`define CCU_MODE_CMP_SET    4'h8
`define CCU_MODE_CMP_CLEAR  4'h9
`define CCU_MODE_CMP_SWINT  4'hA
`define CCU_MODE_CMP_TRIG   4'hB
`endif

// ### inc/ccu_pkg.sv
// Types shared by the capture and compare unit and its surroundings
package ccu_pkg;
    typedef logic [3:0]  mode_t;
    typedef logic [2:0]  src_sel_t;
    typedef logic [15:0] count_t;
    typedef enum logic [1:0] {
        CLASS_OFF     = 2'b00,
        CLASS_CAPTURE = 2'b01,
        CLASS_COMPARE = 2'b10
    } mode_class_t;
endpackage

// ### inc/ccu_if.sv
// Link between the capture/compare unit and its time base, sources and converter
`timescale 1ns/1ps
interface ccu_if;
    logic [15:0] time_base_count;
    logic        time_base_reset;
    logic        remapped_input_pin;
    logic        comparator_one_synced;
    logic        comparator_two_synced;
    logic        pin_change_event;
    logic [3:0]  logic_cell_outputs;
    logic        compare_output;
    logic        conversion_trigger;
    logic        unit_event_flag;
    logic        wake_request;
    modport unit (
        input  time_base_count, remapped_input_pin, comparator_one_synced,
               comparator_two_synced, pin_change_event, logic_cell_outputs,
        output time_base_reset, compare_output, conversion_trigger,
               unit_event_flag, wake_request
    );
    modport env (
        output time_base_count, remapped_input_pin, comparator_one_synced,
               comparator_two_synced, pin_change_event, logic_cell_outputs,
        input  time_base_reset, compare_output, conversion_trigger,
               unit_event_flag, wake_request
    );
endinterface

// ### rtl/ccu_environment.sv
// Far end: sixteen-bit time base with reset input, source routing, trigger capture
`timescale 1ns/1ps
`include "ccu_consts.svh"

module ccu_environment
    import ccu_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_time_base_run,
    input  wire logic        i_remapped_input_pin,
    input  wire logic        i_comparator_one_synced,
    input  wire logic        i_comparator_two_synced,
    input  wire logic        i_pin_change_event,
    input  wire logic [3:0]  i_logic_cell_outputs,
    output logic [15:0]      o_time_base_count,
    output logic             o_compare_output,
    output logic             o_conversion_start,
    output logic             o_unit_event_flag,
    output logic             o_wake,
    ccu_if.env               bus
);
    logic [15:0] count_reg;
    logic        cmp_reg;
    logic        conv_reg;
    logic        flag_reg;
    logic        wake_reg;

    // Synchronous time base; counts only while running and honours unit reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            count_reg <= `CCU_VALUE_RESET;
        else if (bus.time_base_reset)
            count_reg <= `CCU_VALUE_RESET; // RL18
        else if (i_time_base_run)
            count_reg <= count_reg + 16'h0001; // RL7 RL9
    end

    // Registered copies of unit outputs for the user side
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmp_reg  <= 1'b0;
            conv_reg <= 1'b0;
            flag_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            cmp_reg  <= bus.compare_output; // RL21
            conv_reg <= bus.conversion_trigger;
            flag_reg <= bus.unit_event_flag;
            wake_reg <= bus.wake_request;
        end
    end

    assign bus.time_base_count       = count_reg;
    assign bus.remapped_input_pin    = i_remapped_input_pin;
    assign bus.comparator_one_synced = i_comparator_one_synced;
    assign bus.comparator_two_synced = i_comparator_two_synced;
    assign bus.pin_change_event      = i_pin_change_event;
    assign bus.logic_cell_outputs    = i_logic_cell_outputs;
    assign o_time_base_count         = count_reg;
    assign o_compare_output          = cmp_reg;
    assign o_conversion_start        = conv_reg;
    assign o_unit_event_flag         = flag_reg;
    assign o_wake                    = wake_reg;
endmodule // ccu_environment

// ### bench/ccu_monitor.sv
// Interface checker for the capture and compare link
`timescale 1ns/1ps
module ccu_monitor (
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic [15:0] time_base_count,
    input wire logic        time_base_reset,
    input wire logic        compare_output,
    input wire logic        conversion_trigger,
    input wire logic        unit_event_flag,
    input wire logic        wake_request
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Pulse widths and their causes
    property p_tbr_pulse; time_base_reset |=> !time_base_reset; endproperty
    a_tbr_pulse: assert property (p_tbr_pulse) else $error("timer reset too long");
    property p_trig_pulse; conversion_trigger |=> !conversion_trigger; endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
    property p_trig_flag; conversion_trigger |-> unit_event_flag; endproperty
    a_trig_flag: assert property (p_trig_flag) else $error("trigger without flag");
    property p_trig_first; conversion_trigger |-> !time_base_reset; endproperty
    a_trig_first: assert property (p_trig_first) else $error("reset with trigger");
    property p_tbr_flag; time_base_reset |-> unit_event_flag; endproperty
    a_tbr_flag: assert property (p_tbr_flag) else $error("reset without flag");
    property p_tbr_zero; time_base_reset |=> time_base_count == 16'h0000; endproperty
    a_tbr_zero: assert property (p_tbr_zero) else $error("count not cleared");
    property p_wake; wake_request |-> $past(unit_event_flag); endproperty
    a_wake: assert property (p_wake) else $error("wake without flag");
    // The time base only steps up by one or restarts
    property p_step;
        $changed(time_base_count) |->
            time_base_count == $past(time_base_count) + 16'h0001 || time_base_count == 16'h0000;
    endproperty
    a_step: assert property (p_step) else $error("time base jumped");
    // Main scenarios reached
    c_tbr: cover property (time_base_reset);
    c_wake: cover property (wake_request);
    c_out: cover property ($rose(compare_output));
endmodule // ccu_monitor

// ### bench/tb_capture_compare_unit.sv
// Self-checking bench for the capture and compare unit and its far end
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_capture_compare_unit;
    import ccu_pkg::*;
    logic        i_clk = 1'b0, i_rst_b = 1'b0, flag_clr = 1'b0;
    logic        ev_en = 1'b0, trig_sel = 1'b0, run = 1'b0, env_out;
    logic        env_conv, env_flag, env_wake;
    logic [3:0]  we = 4'h0;
    logic [7:0]  wdata = 8'h00, srcs = 8'h00, ctrl_q, lo_q, hi_q;
    logic [2:0]  src_q;
    logic [15:0] v, env_cnt;
    int          n_mismatch = 0, checked = 0, seed = 47697, n;
    mode_t       cm [5] = '{4'h8, 4'h2, 4'h9, 4'hA, 4'hB};
    ccu_if bus ();
    capture_compare_unit i_capture_compare_unit (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_ctrl_we(we[0]), .i_ctrl_wdata(wdata), .i_src_we(we[1]), .i_src_wdata(wdata[2:0]),
        .i_value_low_we(we[2]), .i_value_high_we(we[3]), .i_value_wdata(wdata),
        .i_flag_clear(flag_clr), .i_unit_event_enable(ev_en), .i_trigger_selected(trig_sel),
        .o_unit_control_reg(ctrl_q), .o_value_low_byte(lo_q), .o_value_high_byte(hi_q),
        .o_capture_source_reg(src_q), .bus(bus));
    ccu_environment i_ccu_environment (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_time_base_run(run), .i_remapped_input_pin(srcs[0]),
        .i_comparator_one_synced(srcs[1]), .i_comparator_two_synced(srcs[2]),
        .i_pin_change_event(srcs[3]), .i_logic_cell_outputs(srcs[7:4]),
        .o_time_base_count(env_cnt), .o_compare_output(env_out), .o_conversion_start(env_conv),
        .o_unit_event_flag(env_flag), .o_wake(env_wake), .bus(bus));
    ccu_monitor i_ccu_monitor (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .time_base_count(bus.time_base_count), .time_base_reset(bus.time_base_reset),
        .compare_output(bus.compare_output), .conversion_trigger(bus.conversion_trigger),
        .unit_event_flag(bus.unit_event_flag), .wake_request(bus.wake_request));
    // Clock at 50 MHz
    always #10 i_clk = ~i_clk;
    // Expected latch after a match from a cleared latch, and edges per capture
    function logic exp_out(mode_t m); return m == 4'h8 || m == 4'h2; endfunction
    function int edges(int m); return m == 6 ? 4 : m == 7 ? 16 : 1; endfunction
    task tick; @(posedge i_clk); #2; endtask
    task wr(input int k, input logic [7:0] d); wdata = d; we[k] = 1'b1; tick; we = 4'h0; tick;
    endtask
    task clr; flag_clr = 1'b1; tick; flag_clr = 1'b0; tick; endtask
    task pulse(input int s); srcs[s] = 1'b1; repeat (2) tick; srcs[s] = 1'b0; repeat (5) tick;
    endtask
    task wrap_up;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task wait_flag;
        for (n = 0; n < 100 && bus.unit_event_flag !== 1'b1; n++) tick;
        if (n == 100) begin n_mismatch++; wrap_up; end
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge i_clk);
        #2 i_rst_b = 1'b1;
        tick;
        `CHK("ctrl", 8'h00, ctrl_q)
        `CHK("value", 16'h0000, {hi_q, lo_q})
        // Each source captures, a neighbour does not; timer held as in sleep
        for (int s = 0; s < 8; s++) begin
            wr(0, 8'h00); wr(1, 8'(s)); wr(0, 8'h85); clr;
            `CHK("src", 3'(s), src_q)
            `CHK("ctrl", 8'h85, ctrl_q)
            run = 1'b1; repeat ($unsigned($random(seed)) % 40 + 1) tick; run = 1'b0; tick;
            pulse((s + 1) % 8);
            `CHK("flag", 1'b0, bus.unit_event_flag)
            pulse(s);
            `CHK("flag", 1'b1, bus.unit_event_flag)
            `CHK("value", bus.time_base_count, {hi_q, lo_q})
        end
        // Edge kinds and prescale ratios, each capture overwriting the last
        wr(1, 8'h00);
        for (int m = 4; m < 8; m++) begin
            wr(0, 8'h00); wr(0, 8'h80 | 8'(m)); clr;
            run = 1'b1; repeat (3) tick; run = 1'b0; tick;
            repeat (edges(m) - 1) pulse(0);
            `CHK("flag", 1'b0, bus.unit_event_flag)
            pulse(0);
            `CHK("flag", 1'b1, bus.unit_event_flag)
            `CHK("value", bus.time_base_count, {hi_q, lo_q})
        end
        // Turning off drops a partly counted prescale
        wr(0, 8'h00); wr(0, 8'h86); clr; pulse(0); pulse(0);
        wr(0, 8'h00); wr(0, 8'h86); clr;
        repeat (3) pulse(0);
        `CHK("flag", 1'b0, bus.unit_event_flag)
        pulse(0);
        `CHK("flag", 1'b1, bus.unit_event_flag)
        // Ratio change without zeroing keeps two counted edges
        wr(0, 8'h00); wr(0, 8'h87); clr; pulse(0); pulse(0);
        wr(0, 8'h86); clr; pulse(0);
        `CHK("flag", 1'b0, bus.unit_event_flag)
        pulse(0);
        `CHK("flag", 1'b1, bus.unit_event_flag)
        // Compare modes against random targets ahead of a running time base
        run = 1'b1;
        for (int i = 0; i < 10; i++) begin
            wr(0, 8'h00); tick;
            `CHK("latch", 1'b0, bus.compare_output)
            trig_sel = 1'($random(seed)); ev_en = 1'($random(seed));
            v = bus.time_base_count + 16'h0030 + 16'($unsigned($random(seed)) % 8);
            wr(2, v[7:0]); wr(3, v[15:8]);
            `CHK("value", v, {hi_q, lo_q})
            wr(0, 8'h80 | 8'(cm[i % 5])); clr;
            wait_flag;
            `CHK("count", v + 16'h0001, bus.time_base_count)
            `CHK("latch", exp_out(cm[i % 5]), bus.compare_output)
            `CHK("trigger", trig_sel, bus.conversion_trigger)
            tick;
            `CHK("wake", ev_en, bus.wake_request)
            `CHK("copy", bus.compare_output, env_out)
            `CHK("copy trigger", trig_sel, env_conv)
            `CHK("copy flag", 1'b1, env_flag)
            tick;
            `CHK("copy wake", ev_en, env_wake)
            if (cm[i % 5] == 4'hB) begin
                `CHK("count", 16'h0000, bus.time_base_count)
                `CHK("copy count", 16'h0000, env_cnt)
            end
            `CHK("flag", 1'b1, bus.unit_event_flag)
            clr;
            `CHK("flag", 1'b0, bus.unit_event_flag)
        end
        // Moving the pair right after a trigger-mode match keeps the time base running
        wr(0, 8'h00);
        v = bus.time_base_count + 16'h0030;
        wr(2, v[7:0]); wr(3, v[15:8]); wr(0, 8'h8B); clr;
        for (n = 0; n < 100 && bus.time_base_count !== v; n++) tick;
        if (n == 100) begin n_mismatch++; wrap_up; end
        wr(2, v[7:0] ^ 8'h80);
        tick;
        `CHK("flag", 1'b1, bus.unit_event_flag)
        `CHK("count", v + 16'h0003, bus.time_base_count)
        wrap_up;
    end
endmodule // tb_capture_compare_unit
